// ### rtl/mzt_entry_mem.sv
// translation entry memory, low words and process tags, not touched by reset
module mzt_entry_mem #(
    parameter int AW = 6 // index width
) (
    input  wire logic          clk,       // core clock
    input  wire logic          lo_we,     // write low word
    input  wire logic [31:0]   lo_wdata,  // low word data
    input  wire logic          tag_we,    // write entry process tag
    input  wire logic [7:0]    tag_wdata, // tag data
    input  wire logic [AW-1:0] waddr,     // write index
    input  wire logic [AW-1:0] raddr,     // read index
    output logic      [31:0]   lo_rdata,  // registered low word
    output logic      [7:0]    tag_rdata  // registered tag
);
    logic [31:0] lo_mem  [2**AW]; // low words
    logic [7:0]  tag_mem [2**AW]; // entry process tags

    // load-time contents only; no reset port so resets leave entries alone
    initial
    begin
        for (int i = 0; i < 2**AW; i++)
        begin
            lo_mem[i]  = mzt_pkg::LOW_WORD_INIT;
            tag_mem[i] = 8'h00;
        end
    end

    // writes and registered reads
    always_ff @(posedge clk)
    begin
        if (lo_we)
            lo_mem[waddr] <= lo_wdata;
        if (tag_we)
            tag_mem[waddr] <= tag_wdata;
        lo_rdata  <= lo_mem[raddr];
        tag_rdata <= tag_mem[raddr];
    end
endmodule

// ### rtl/mzt_pkg.sv
// shared constants and carrier types for the mmu zone and translation register slice
package mzt_pkg;
    localparam logic [13:0] SEL_PROCESS_TAG  = 14'h1000; // process tag selector
    localparam logic [13:0] SEL_ZONE         = 14'h1001; // zone override selector
    localparam logic [13:0] SEL_TRANS_LOW    = 14'h1003; // translation low word selector
    localparam logic [13:0] SEL_TRANS_HIGH   = 14'h1004; // translation high word selector
    localparam logic [7:0]  PROCESS_TAG_RST  = 8'h00;    // process tag after reset
    localparam logic [31:0] ZONE_RST         = 32'h00000000; // zone override after reset
    localparam logic [31:0] LOW_WORD_INIT    = 32'h00000000; // buffer low word at load
    localparam int          TAG_LSB          = 0;        // identifier in bits 24:31 (msb0)
    localparam int          USER_THRESHOLD   = 1;        // mmu level above this has regs
    localparam int          ZONE_SEL_LSB     = 4;        // zone select, msb0 bits 24:27
    localparam int          EXEC_BIT         = 9;        // executable, msb0 bit 22
    localparam int          WR_BIT           = 8;        // writable, msb0 bit 23
    localparam logic [1:0]  ZONE_DENY        = 2'h0;     // zone code 00
    localparam logic [1:0]  ZONE_FULL        = 2'h3;     // zone code 11
    localparam logic [1:0]  ACC_NONE         = 2'h0;     // access param: no access
    localparam logic [1:0]  ACC_MINIMAL      = 2'h1;     // access param: read only
    localparam logic [1:0]  ACC_WRITE        = 2'h2;     // access param: write only
    localparam logic [1:0]  ACC_FULL         = 2'h3;     // access param: full

    // one special-register move from the pipeline
    typedef struct packed {
        logic        wr;   // move to special
        logic        rd;   // move from special
        logic [13:0] sel;  // special register selector
        logic [31:0] data; // write data
    } mzt_move_s;

    // effective page permission after zone override
    typedef struct packed {
        logic valid; // page accessible
        logic wr;    // writable
        logic ex;    // executable
    } mzt_perm_s;
endpackage

// ### rtl/mzt_regs.sv
// process tag, zone override and translation low word special registers
module mzt_regs #(
    parameter int         MMU_LEVEL  = 3,     // mmu_level_param
    parameter bit         AREA_OPT   = 1'b0,  // area_optimize_param
    parameter int         ZONE_COUNT = 16,    // zone_count_param
    parameter logic [1:0] ACCESS     = 2'h3,  // translation_access_param
    parameter int         AW         = 6      // translation index width
) (
    input  wire logic                 clk,          // core clock
    input  wire logic                 reset,        // async, active high
    input  wire mzt_pkg::mzt_move_s   move,         // special-register move, one cycle
    input  wire logic [AW-1:0]        index,        // translation_index_reg value
    input  wire logic                 user_mode_flag, // machine_state_reg user bit
    input  wire logic [31:0]          lookup_low,   // low word of hit entry
    input  wire logic                 lookup_valid, // valid bit of hit entry
    input  wire logic                 fetch,        // instruction fetch on hit entry
    output logic [31:0]               rdata,        // move-from data
    output logic                      rdata_valid,  // move-from data strobe
    output mzt_pkg::mzt_perm_s        perm,         // effective page permission
    output logic                      fetch_fault   // instruction-storage exception
);
    // the special registers vanish at user-only or area-optimized levels; perm and fetch_fault still work
    localparam bit HAS_REGS = (MMU_LEVEL > mzt_pkg::USER_THRESHOLD) && !AREA_OPT;
    // the zone register additionally needs at least one zone
    localparam bit HAS_ZONE = HAS_REGS && (ZONE_COUNT > 0);
    // low word move-from only for the read-capable access settings
    localparam bit CAN_RD   = (ACCESS == mzt_pkg::ACC_MINIMAL) || (ACCESS == mzt_pkg::ACC_FULL);
    // low word move-to only for the write-capable access settings
    localparam bit CAN_WR   = (ACCESS == mzt_pkg::ACC_WRITE) || (ACCESS == mzt_pkg::ACC_FULL);

    // architectural state, memory read data and read bookkeeping
    logic [7:0]  process_tag_reg;   // current process identifier
    logic [31:0] zone_override_reg; // zone fields
    logic [31:0] lo_rdata;          // low word from memory
    logic [7:0]  tag_rdata;         // entry tag from memory
    logic        lo_rd_pend;        // low word read in flight
    logic        hi_rd_pend;        // high word read in flight
    logic        hi_rd_priv;        // high read done while privileged
    logic [31:0] zone_mask;         // implemented zone bits
    logic [1:0]  zone_code;         // selected zone field
    mzt_pkg::mzt_perm_s perm_next;  // combinational permission

    // decode helper used for several selectors
    // keeps every selector compare at the same width and in one place
    function automatic logic hit(input mzt_pkg::mzt_move_s m, input logic [13:0] s);
        return m.sel == s;
    endfunction

    // implemented zone bits; msb0 field n sits at lsb0 bits 31-2n, 30-2n
    // fields beyond the zone count read back as zero, code 00, which denies the page in user mode
    // the mask is constant, so it folds away into the write path
    always_comb
    begin
        zone_mask = 32'h00000000;
        for (int n = 0; n < 16; n++)
            if (n < ZONE_COUNT)
                zone_mask[31-2*n -: 2] = 2'h3;
    end

    // entry storage; no reset connected on purpose
    // low words start at zero from the load image only
    // none of the resets reaches the memory, so entries survive them
    // reads are registered, which costs one cycle on low word answers
    mzt_entry_mem #(
        .AW (AW)
    ) u_mem (
        .clk       (clk),
        .lo_we     (HAS_REGS && CAN_WR && move.wr && hit(move, mzt_pkg::SEL_TRANS_LOW)),
        .lo_wdata  (move.data),
        .tag_we    (HAS_REGS && move.wr && hit(move, mzt_pkg::SEL_TRANS_HIGH)),
        .tag_wdata (process_tag_reg),
        .waddr     (index),
        .raddr     (index),
        .lo_rdata  (lo_rdata),
        .tag_rdata (tag_rdata)
    );

    // process tag: moves, and load from entry on privileged high read
    // a privileged high word read wins over a same-cycle tag write,
    // since the loaded tag belongs to the entry software just chose
    // only the low byte is stored; upper bits cannot hold anything
    // the load lands one edge after the read request is taken
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            process_tag_reg <= mzt_pkg::PROCESS_TAG_RST;
        else if (HAS_REGS)
        begin
            if (hi_rd_pend && hi_rd_priv)
                process_tag_reg <= tag_rdata;
            else if (move.wr && hit(move, mzt_pkg::SEL_PROCESS_TAG))
                process_tag_reg <= move.data[7:0];
        end
    end

    // zone override register, unimplemented fields stay zero
    // masking on write keeps unimplemented fields at zero on read
    // so software can probe the zone count by writing all ones
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            zone_override_reg <= mzt_pkg::ZONE_RST;
        else if (HAS_ZONE && move.wr && hit(move, mzt_pkg::SEL_ZONE))
            zone_override_reg <= move.data & zone_mask;
    end

    // pending memory reads; memory data arrives one cycle later
    // the memory answers one edge after the request, so the request
    // kind and the mode at that edge are kept for the following edge
    // the mode is captured every cycle; only the high read uses it
    // a user-mode high read thus leaves the process tag alone
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lo_rd_pend <= 1'b0;
            hi_rd_pend <= 1'b0;
            hi_rd_priv <= 1'b0;
        end
        else
        begin
            lo_rd_pend <= HAS_REGS && CAN_RD && move.rd
                          && hit(move, mzt_pkg::SEL_TRANS_LOW);
            hi_rd_pend <= HAS_REGS && move.rd && hit(move, mzt_pkg::SEL_TRANS_HIGH);
            hi_rd_priv <= !user_mode_flag;
        end
    end

    // read data: registers answer next cycle, low word answers with memory
    // the low word answer has priority; the pipeline must not issue a
    // register read right after a low word read, or that answer is lost
    // rdata holds its last value between answers to save toggling
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rdata       <= 32'h00000000;
            rdata_valid <= 1'b0;
        end
        else if (lo_rd_pend)
        begin
            rdata       <= lo_rdata;
            rdata_valid <= 1'b1;
        end
        else if (HAS_REGS && move.rd && hit(move, mzt_pkg::SEL_PROCESS_TAG))
        begin
            rdata       <= {24'h000000, process_tag_reg};
            rdata_valid <= 1'b1;
        end
        else if (HAS_ZONE && move.rd && hit(move, mzt_pkg::SEL_ZONE))
        begin
            rdata       <= zone_override_reg;
            rdata_valid <= 1'b1;
        end
        else
            rdata_valid <= 1'b0;
    end

    // zone override of entry protection; no zones means entry bits stand
    // user mode: 00 takes the page away, 11 opens it fully
    // privileged: the upper code bit alone opens the page
    // entry bits are the default; overrides only widen or deny
    always_comb
    begin
        zone_code = 2'h1; // no zones: behave as a pass-through code
        if (HAS_ZONE)
            zone_code = zone_override_reg[31-2*lookup_low[mzt_pkg::ZONE_SEL_LSB +: 4] -: 2];
        // start from the entry's own protection
        perm_next.valid = lookup_valid;
        perm_next.wr    = lookup_low[mzt_pkg::WR_BIT];
        perm_next.ex    = lookup_low[mzt_pkg::EXEC_BIT];
        // deny clears valid too, so nothing at all reaches the page
        // in user mode codes 01 and 10 fall through with the entry bits untouched
        if (user_mode_flag)
        begin
            if (zone_code == mzt_pkg::ZONE_DENY)
                perm_next = '0;
            else if (zone_code == mzt_pkg::ZONE_FULL)
            begin
                perm_next.wr = 1'b1;
                perm_next.ex = 1'b1;
            end
        end
        else if (zone_code[1])
        begin
            perm_next.wr = 1'b1;
            perm_next.ex = 1'b1;
        end
    end

    // registered permission and fetch fault
    // registering costs a cycle but keeps the outputs glitch free
    // the fault uses the same next value, so it lines up with perm
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            perm        <= '0;
            fetch_fault <= 1'b0;
        end
        else
        begin
            perm        <= perm_next;
            fetch_fault <= fetch && !perm_next.ex;
        end
    end
endmodule

// ### sim/mzt_pipe_model.sv
// pipeline model issuing special-register moves
module mzt_pipe_model (
    input  wire logic             clk,         // core clock
    input  wire logic [31:0]      rdata,       // move-from data
    input  wire logic             rdata_valid, // answer strobe
    output mzt_pkg::mzt_move_s    move,        // move request
    output logic      [5:0]       index        // entry index, held after move
);
    timeunit 1ns;
    timeprecision 1ns;
    initial move = '0;
    initial index = 6'h00;
    // one-cycle move, then three edges for an answer; spacing avoids overlap
    task automatic op(input logic w, input logic r, input logic [13:0] s,
                      input logic [31:0] d, input logic [5:0] i, output logic [31:0] got);
        got = 32'hEEEEEEEE; // marker kept when no answer comes
        @(posedge clk);
        move <= {w, r, s, d};
        index <= i;
        @(posedge clk);
        move.wr <= 1'b0;
        move.rd <= 1'b0;
        repeat (3)
        begin
            @(posedge clk);
            if (rdata_valid === 1'b1)
                got = rdata;
        end
    endtask
endmodule

// ### sim/mzt_regs_monitor.sv
// concurrent checks on the tag, zone and translation low word slice
module mzt_regs_monitor (
    input wire logic               clk,            // core clock
    input wire logic               reset,          // async reset
    input wire mzt_pkg::mzt_move_s move,           // move request
    input wire logic [5:0]         index,          // entry index
    input wire logic               user_mode_flag, // user mode
    input wire logic [31:0]        lookup_low,     // entry low word
    input wire logic               lookup_valid,   // entry valid
    input wire logic               fetch,          // fetch pulse
    input wire logic [31:0]        rdata,          // move-from data
    input wire logic               rdata_valid,    // answer strobe
    input wire mzt_pkg::mzt_perm_s perm,           // effective permission
    input wire logic               fetch_fault     // storage exception
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [31:0] zone_reg; // shadow of the zone override
    logic [1:0]  code;     // zone code picked by the entry
    // shadow follows writes so perm checks need no design internals
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            zone_reg <= 32'h00000000;
        else if (move.wr && move.sel == 14'h1001)
            zone_reg <= move.data;
    end
    assign code = zone_reg[(31 - 2 * lookup_low[7:4]) -: 2];
    // register reads answer on the next edge, tag reads with zero upper bits
    a_tag_read: assert property (
        move.rd && move.sel == 14'h1000 |=> rdata_valid && rdata[31:8] == 24'h000000)
        else $error("tag read");
    a_zone_read: assert property (
        move.rd && move.sel == 14'h1001 |=> rdata_valid && rdata == $past(zone_reg))
        else $error("zone read");
    // low word answers one edge later, behind the memory register
    a_low_read_lat: assert property (
        move.rd && move.sel == 14'h1003 |=> !rdata_valid ##1 rdata_valid)
        else $error("low read timing");
    a_unknown_sel: assert property (
        move.rd && move.sel == 14'h0FFF |=> !rdata_valid)
        else $error("unknown answered");
    a_fetch_fault: assert property (
        fetch |=> fetch_fault == !perm.ex)
        else $error("fetch fault");
    // permission follows the shadow zone code one edge later
    a_user_deny: assert property (
        user_mode_flag && code == 2'h0 |=> !perm.valid && !perm.wr && !perm.ex)
        else $error("deny");
    a_user_pass: assert property (
        user_mode_flag && code != 2'h0 && code != 2'h3
        |=> perm == {$past(lookup_valid), $past(lookup_low[8]), $past(lookup_low[9])})
        else $error("user pass");
    a_zone_full: assert property (
        (user_mode_flag ? code == 2'h3 : code[1]) |=> perm.wr && perm.ex)
        else $error("full");
    a_priv_pass: assert property (
        !user_mode_flag && !code[1]
        |=> perm == {$past(lookup_valid), $past(lookup_low[8]), $past(lookup_low[9])})
        else $error("priv pass");
    c_low_read: cover property (move.rd && move.sel == 14'h1003 ##2 rdata_valid);
    c_deny: cover property (user_mode_flag && code == 2'h0 && lookup_valid);
    c_fault: cover property (fetch ##1 fetch_fault);
endmodule
bind mzt_regs mzt_regs_monitor mon_u (.clk(clk), .reset(reset), .move(move), .index(index),
    .user_mode_flag(user_mode_flag), .lookup_low(lookup_low), .lookup_valid(lookup_valid),
    .fetch(fetch), .rdata(rdata), .rdata_valid(rdata_valid), .perm(perm),
    .fetch_fault(fetch_fault));

// ### sim/tb.sv
// self-checking bench for the tag, zone and translation low word slice
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk;            // core clock
    logic               reset;          // async reset
    logic               user_mode_flag; // user mode
    logic               lookup_valid;   // entry valid
    logic               fetch;          // fetch pulse
    logic               rdata_valid;    // answer strobe
    logic               fetch_fault;    // storage exception
    logic               full;           // expected full override
    logic               deny;           // expected zone denial
    logic [5:0]         index;      // entry index
    logic [31:0]        lookup_low; // looked-up low word
    logic [31:0]        rdata;      // move-from data
    logic [31:0]        got;        // captured answer
    logic [1:0]         code;       // expected zone code
    mzt_pkg::mzt_move_s move;       // move request
    mzt_pkg::mzt_perm_s perm;       // effective permission
    int                 fail_count;
    int                 comparisons;
    mzt_regs dut_u (.clk(clk), .reset(reset), .move(move), .index(index),
        .user_mode_flag(user_mode_flag), .lookup_low(lookup_low), .lookup_valid(lookup_valid),
        .fetch(fetch), .rdata(rdata), .rdata_valid(rdata_valid), .perm(perm),
        .fetch_fault(fetch_fault));
    mzt_pipe_model pipe_u (.clk(clk), .rdata(rdata), .rdata_valid(rdata_valid),
        .move(move), .index(index));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic test_done();
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog well beyond the roughly 130 cycles the sequence needs
    initial
    begin
        #100000;
        fail_count++;
        test_done();
    end
    initial
    begin
        {reset, user_mode_flag, lookup_valid, fetch, lookup_low} = 36'h800000000;
        fail_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        pipe_u.op(0, 1, 14'h1000, 0, 0, got);
        check(got, 32'h00000000);
        pipe_u.op(0, 1, 14'h1001, 0, 0, got);
        check(got, 32'h00000000);
        pipe_u.op(1, 0, 14'h1000, 32'h123456A5, 0, got);
        pipe_u.op(0, 1, 14'h1000, 0, 0, got);
        check(got, 32'h000000A5);
        pipe_u.op(1, 0, 14'h1001, 32'h1B1B1B1B, 0, got);
        pipe_u.op(0, 1, 14'h1001, 0, 0, got);
        check(got, 32'h1B1B1B1B);
        // an unknown selector gets no answer, so the marker survives
        pipe_u.op(0, 1, 14'h0FFF, 0, 0, got);
        check(got, 32'hEEEEEEEE);
        // zones 0..3 hold codes 00,01,10,11; entry writable, not executable
        for (int i = 0; i < 8; i++)
        begin
            code = 2'((8'h1B >> (6 - 2 * (i >> 1))) & 8'h03);
            deny = i[0] && code == 2'h0;
            full = i[0] ? (code == 2'h3) : code[1];
            @(posedge clk);
            lookup_low <= 32'(32'h00000100 | ((i >> 1) << 4));
            lookup_valid <= 1'b1;
            user_mode_flag <= i[0];
            fetch <= 1'b1;
            @(posedge clk);
            fetch <= 1'b0;
            #1;
            got = 32'({perm.valid, perm.wr, perm.ex, fetch_fault});
            check(got, 32'({!deny, !deny, full, !full}));
        end
        @(posedge clk);
        user_mode_flag <= 1'b0;
        pipe_u.op(1, 0, 14'h1003, 32'hABCD1230, 6'h05, got);
        pipe_u.op(0, 1, 14'h1003, 0, 6'h06, got);
        check(got, 32'h00000000);
        pipe_u.op(1, 0, 14'h1000, 32'h0000003C, 0, got);
        pipe_u.op(1, 0, 14'h1004, 0, 6'h05, got);
        reset <= 1'b1; // mid-run reset must spare the buffer
        @(posedge clk);
        reset <= 1'b0;
        pipe_u.op(0, 1, 14'h1003, 0, 6'h05, got);
        check(got, 32'hABCD1230);
        pipe_u.op(0, 1, 14'h1000, 0, 0, got);
        check(got, 32'h00000000);
        pipe_u.op(0, 1, 14'h1004, 0, 6'h05, got);
        pipe_u.op(0, 1, 14'h1000, 0, 0, got);
        check(got, 32'h0000003C);
        user_mode_flag <= 1'b1;
        pipe_u.op(1, 0, 14'h1000, 32'h00000011, 0, got);
        pipe_u.op(0, 1, 14'h1004, 0, 6'h05, got);
        pipe_u.op(0, 1, 14'h1000, 0, 0, got);
        check(got, 32'h00000011);
        test_done();
    end
endmodule
